// >>> inc/pic_pkg.sv
// Purpose: Shared constants and types of the priority interrupt controller.
// Assumes: AHB-Lite register bus, 32-bit data, one clock.
// Notes:   Offsets are byte addresses of aligned words.
package pic_pkg;

	// Register byte offsets.
	localparam logic [11:0] OFS_STATUS      = 12'h000;
	localparam logic [11:0] OFS_PENDING     = 12'h004;
	localparam logic [11:0] OFS_ENABLE      = 12'h008;
	localparam logic [11:0] OFS_ACK         = 12'h00C;
	localparam logic [11:0] OFS_SET_ENABLE  = 12'h010;
	localparam logic [11:0] OFS_CLR_ENABLE  = 12'h014;
	localparam logic [11:0] OFS_VECTOR_IDX  = 12'h018;
	localparam logic [11:0] OFS_MASTER      = 12'h01C;
	localparam logic [11:0] OFS_MODE        = 12'h020;
	localparam logic [11:0] OFS_VECTOR_BASE = 12'h100;
	localparam logic [11:0] OFS_VECTOR_LAST = 12'h17C;

	// Master enable register fields.
	localparam int unsigned MASTER_REQ_BIT = 0;
	localparam int unsigned MASTER_HW_BIT  = 1;

	// Reset values.
	localparam logic [31:0] RST_WORD = 32'h0000_0000;
	localparam logic [1:0]  RST_MASTER = 2'h0;

	// AHB transfer type bit that marks NONSEQ or SEQ.
	localparam int unsigned HTRANS_ACTIVE_BIT = 1;

	// Captured AHB address phase.
	typedef struct packed {
		logic        valid;
		logic        write;
		logic [11:0] addr;
	} ahb_phase_s;

	// Fast mode vector hand-off states.
	typedef enum logic [1:0] {
		FAST_IDLE = 2'b01,
		FAST_WAIT = 2'b10
	} fast_state_e;

endpackage : pic_pkg

// >>> verilog/priority_interrupt_controller.sv
// Purpose: Priority interrupt controller with AHB-Lite registers and fast mode.
// Assumes: Interrupt inputs and the processor acknowledge are asynchronous pins.
// Notes:   Zero wait state slave; a read right after a write sees the old value.
`timescale 1ns/100ps
`default_nettype none

module priority_interrupt_controller #(
	parameter int unsigned          NUM_INTR     = 32,
	parameter bit                   HAS_PENDING  = 1'b1,
	parameter bit                   HAS_SET_EN   = 1'b1,
	parameter bit                   HAS_CLR_EN   = 1'b1,
	parameter bit                   HAS_VEC_IDX  = 1'b1,
	parameter bit                   HAS_FAST     = 1'b1,
	parameter bit                   IRQ_IS_LEVEL = 1'b1,
	parameter logic [NUM_INTR-1:0]  KIND_EDGE    = '1,
	parameter logic [NUM_INTR-1:0]  EDGE_RISING  = '1,
	parameter logic [NUM_INTR-1:0]  LEVEL_HIGH   = '1
) (
	// Clock, reset and clock enable.
	input  wire logic                hclk,
	input  wire logic                hresetn,
	input  wire logic                ce,
	// AHB-Lite slave.
	input  wire logic                hsel,
	input  wire logic [31:0]         haddr,
	input  wire logic [1:0]          htrans,
	input  wire logic                hwrite,
	input  wire logic [2:0]          hsize,
	input  wire logic [31:0]         hwdata,
	input  wire logic                hready,
	output logic                     hreadyout,
	output logic                     hresp,
	output logic [31:0]              hrdata,
	// Peripheral interrupt pins.
	input  wire logic [NUM_INTR-1:0] intr,
	// Processor side.
	input  wire logic                processor_ack,
	output logic                     irq,
	output logic [31:0]              vector_address
);

	localparam int unsigned IDXW = (NUM_INTR > 1) ? $clog2(NUM_INTR) : 1;

	// Register state.
	logic [NUM_INTR-1:0] status_bits;
	logic [NUM_INTR-1:0] enable_bits;
	logic [NUM_INTR-1:0] mode_bits;
	logic [1:0]          master_enable_reg;
	logic [31:0]         vector_address_reg [NUM_INTR];
	pic_pkg::ahb_phase_s ap;

	// Pin synchronisers and filtered levels.
	logic [NUM_INTR-1:0] intr_s1, intr_s2, intr_s3, intr_stable, intr_prev;
	logic                ack_s1, ack_s2, ack_s3, ack_stable;

	// Request path.
	logic                req_q;
	pic_pkg::fast_state_e fast_state;
	logic [IDXW-1:0]     fast_idx;

	// Combinational terms.
	logic [NUM_INTR-1:0] hw_valid, sw_set, set_vec, ack_vec, fast_ack_vec;
	logic [NUM_INTR-1:0] enabled_pending, wr_bits;
	logic [IDXW-1:0]     top_idx;
	logic                any_pending, master_request_enable, hardware_input_enable;
	logic                ack_event, data_wr;
	logic [31:0]         rd_value, vector_index_reg;
	logic [11:0]         rd_addr;

	assign master_request_enable = master_enable_reg[pic_pkg::MASTER_REQ_BIT];
	assign hardware_input_enable = master_enable_reg[pic_pkg::MASTER_HW_BIT];
	assign wr_bits               = hwdata[NUM_INTR-1:0];
	assign data_wr               = ap.valid & ap.write;
	assign rd_addr               = {haddr[11:2], 2'h0};

	// Lowest set bit wins, so input zero is always served first.
	function automatic logic [IDXW-1:0] first_set(input logic [NUM_INTR-1:0] v);
		logic [IDXW-1:0] idx;
		idx = '0;
		for (int i = NUM_INTR - 1; i >= 0; i--) begin
			if (v[i]) begin
				idx = IDXW'(i);
			end
		end
		return idx;
	endfunction : first_set

	// Three-stage synchronisers; a level counts once stages two and three agree.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			intr_s1     <= '0;
			intr_s2     <= '0;
			intr_s3     <= '0;
			intr_stable <= '0;
			intr_prev   <= '0;
			ack_s1      <= 1'b0;
			ack_s2      <= 1'b0;
			ack_s3      <= 1'b0;
			ack_stable  <= 1'b0;
		end else if (ce) begin
			intr_s1   <= intr;
			intr_s2   <= intr_s1;
			intr_s3   <= intr_s2;
			intr_prev <= intr_stable;
			for (int i = 0; i < NUM_INTR; i++) begin
				if (intr_s2[i] == intr_s3[i]) begin
					intr_stable[i] <= intr_s2[i];
				end
			end
			ack_s1 <= processor_ack;
			ack_s2 <= ack_s1;
			ack_s3 <= ack_s2;
			if (ack_s2 == ack_s3) begin
				ack_stable <= ack_s2;
			end
		end
	end

	// Valid hardware condition per input: chosen edge, or chosen level.
	always_comb begin
		for (int i = 0; i < NUM_INTR; i++) begin
			if (KIND_EDGE[i]) begin
				hw_valid[i] = EDGE_RISING[i] ? (intr_stable[i] & ~intr_prev[i])
				                             : (~intr_stable[i] & intr_prev[i]);
			end else begin
				hw_valid[i] = (intr_stable[i] == LEVEL_HIGH[i]);
			end
		end
	end

	// Event sources for status and acknowledge.
	always_comb begin
		sw_set = '0;
		if (data_wr && ap.addr == pic_pkg::OFS_STATUS && !hardware_input_enable) begin
			sw_set = wr_bits;
		end
		set_vec = hardware_input_enable ? hw_valid : sw_set;
		fast_ack_vec = '0;
		if (ack_event && fast_state == pic_pkg::FAST_WAIT && mode_bits[fast_idx]) begin
			fast_ack_vec[fast_idx] = 1'b1;
		end
		ack_vec = fast_ack_vec;
		if (data_wr && ap.addr == pic_pkg::OFS_ACK) begin
			ack_vec = ack_vec | wr_bits;
		end
	end

	assign ack_event       = HAS_FAST && ack_s2 == ack_s3 && ack_s2 && !ack_stable;
	assign enabled_pending = status_bits & enable_bits;
	assign any_pending     = |enabled_pending;
	assign top_idx         = first_set(enabled_pending);

	// Status: a new event in the same cycle as its acknowledge is kept.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			status_bits <= pic_pkg::RST_WORD[NUM_INTR-1:0];
		end else if (ce) begin
			status_bits <= (status_bits & ~ack_vec) | set_vec;
		end
	end

	// Enable bits from direct write and from the set and clear aliases.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			enable_bits <= pic_pkg::RST_WORD[NUM_INTR-1:0];
		end else if (ce && data_wr) begin
			if (ap.addr == pic_pkg::OFS_ENABLE) begin
				enable_bits <= wr_bits;
			end else if (HAS_SET_EN && ap.addr == pic_pkg::OFS_SET_ENABLE) begin
				enable_bits <= enable_bits | wr_bits;
			end else if (HAS_CLR_EN && ap.addr == pic_pkg::OFS_CLR_ENABLE) begin
				enable_bits <= enable_bits & ~wr_bits;
			end
		end
	end

	// Master enable; the hardware bit locks once set, until reset.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			master_enable_reg <= pic_pkg::RST_MASTER;
		end else if (ce && data_wr && ap.addr == pic_pkg::OFS_MASTER) begin
			master_enable_reg[pic_pkg::MASTER_REQ_BIT] <= hwdata[pic_pkg::MASTER_REQ_BIT];
			if (!hardware_input_enable) begin
				master_enable_reg[pic_pkg::MASTER_HW_BIT] <= hwdata[pic_pkg::MASTER_HW_BIT];
			end
		end
	end

	// Mode bits and vector addresses exist only with fast mode built in.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mode_bits <= pic_pkg::RST_WORD[NUM_INTR-1:0];
			for (int i = 0; i < NUM_INTR; i++) begin
				vector_address_reg[i] <= pic_pkg::RST_WORD;
			end
		end else if (ce && data_wr && HAS_FAST) begin
			if (ap.addr == pic_pkg::OFS_MODE) begin
				mode_bits <= wr_bits;
			end
			for (int i = 0; i < NUM_INTR; i++) begin
				if (ap.addr == pic_pkg::OFS_VECTOR_BASE + 12'(4 * i)) begin
					vector_address_reg[i] <= hwdata;
				end
			end
		end
	end

	// Request output: level follows pending, edge mode pulses when the gated request rises from low, from pending or from master enable.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			req_q <= 1'b0;
			irq   <= 1'b0;
		end else if (ce) begin
			req_q <= master_request_enable & any_pending;
			if (IRQ_IS_LEVEL) begin
				irq <= master_request_enable & any_pending;
			end else begin
				irq <= master_request_enable & any_pending & ~req_q;
			end
		end
	end

	// Fast mode: latch the winner's address and hold it until the processor acknowledges.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			fast_state     <= pic_pkg::FAST_IDLE;
			fast_idx       <= '0;
			vector_address <= pic_pkg::RST_WORD;
		end else if (ce) begin
			case (fast_state)
				pic_pkg::FAST_IDLE: begin
					if (HAS_FAST && master_request_enable && any_pending && mode_bits[top_idx]) begin
						fast_idx       <= top_idx;
						vector_address <= vector_address_reg[top_idx];
						fast_state     <= pic_pkg::FAST_WAIT;
					end
				end
				pic_pkg::FAST_WAIT: begin
					// Dropping master enable abandons the hand-off so it cannot hang.
					if (ack_event || !master_request_enable) begin
						fast_state <= pic_pkg::FAST_IDLE;
					end
				end
				default: begin
					fast_state <= pic_pkg::FAST_IDLE;
				end
			endcase
		end
	end

	assign vector_index_reg = (HAS_VEC_IDX && any_pending) ? 32'(top_idx) : 32'hFFFF_FFFF;

	// Read multiplexer on the address phase; unmapped words read zero.
	always_comb begin
		rd_value = pic_pkg::RST_WORD;
		case (rd_addr)
			pic_pkg::OFS_STATUS:     rd_value = 32'(status_bits);
			pic_pkg::OFS_PENDING:    rd_value = HAS_PENDING ? 32'(enabled_pending) : 32'h0;
			pic_pkg::OFS_ENABLE:     rd_value = 32'(enable_bits);
			pic_pkg::OFS_VECTOR_IDX: rd_value = vector_index_reg;
			pic_pkg::OFS_MASTER:     rd_value = 32'(master_enable_reg);
			pic_pkg::OFS_MODE:       rd_value = HAS_FAST ? 32'(mode_bits) : 32'h0;
			default: begin
				for (int i = 0; i < NUM_INTR; i++) begin
					if (HAS_FAST && rd_addr == pic_pkg::OFS_VECTOR_BASE + 12'(4 * i)) begin
						rd_value = vector_address_reg[i];
					end
				end
			end
		endcase
	end

	// AHB-Lite slave: address phase captured, write data applied one cycle later.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ap        <= '0;
			hrdata    <= pic_pkg::RST_WORD;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end else if (ce) begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
			if (hready) begin
				ap.valid <= hsel & htrans[pic_pkg::HTRANS_ACTIVE_BIT] & (hsize == 3'h2);
				ap.write <= hwrite;
				ap.addr  <= {haddr[11:2], 2'h0};
				if (hsel && htrans[pic_pkg::HTRANS_ACTIVE_BIT] && !hwrite) begin
					hrdata <= rd_value;
				end
			end
		end
	end

	// Checks.
	property p_mask_master;
		@(posedge hclk) disable iff (!hresetn)
		ce && !master_request_enable |=> !irq;
	endproperty
	a_mask_master: assert property (p_mask_master) else $error("irq while master disabled");

	property p_need_enabled;
		@(posedge hclk) disable iff (!hresetn)
		ce && (status_bits & enable_bits) == '0 |=> !irq;
	endproperty
	a_need_enabled: assert property (p_need_enabled) else $error("irq without enabled input");

	property p_level_output;
		@(posedge hclk) disable iff (!hresetn)
		ce && IRQ_IS_LEVEL && master_request_enable && any_pending |=> irq;
	endproperty
	a_level_output: assert property (p_level_output) else $error("irq missing for pending");

	property p_hw_lock;
		@(posedge hclk) disable iff (!hresetn)
		hardware_input_enable |=> hardware_input_enable [*3];
	endproperty
	a_hw_lock: assert property (p_hw_lock) else $error("hardware enable cleared");

	property p_idx_empty;
		@(posedge hclk) disable iff (!hresetn)
		!any_pending |-> vector_index_reg == 32'hFFFF_FFFF;
	endproperty
	a_idx_empty: assert property (p_idx_empty) else $error("index not all ones");

	property p_idx_top;
		@(posedge hclk) disable iff (!hresetn)
		any_pending |-> enabled_pending[top_idx] &&
			(enabled_pending & ((NUM_INTR'(1) << top_idx) - NUM_INTR'(1))) == '0;
	endproperty
	a_idx_top: assert property (p_idx_top) else $error("index not highest priority");

	property p_sw_set;
		@(posedge hclk) disable iff (!hresetn)
		ce && sw_set != '0 && !hardware_input_enable |=>
			(status_bits & $past(sw_set)) == $past(sw_set);
	endproperty
	a_sw_set: assert property (p_sw_set) else $error("software set lost");

	property p_ack_clear;
		@(posedge hclk) disable iff (!hresetn)
		ce && ack_vec != '0 && set_vec == '0 |=> (status_bits & $past(ack_vec)) == '0;
	endproperty
	a_ack_clear: assert property (p_ack_clear) else $error("acknowledge did not clear");

	property p_disable_keeps;
		@(posedge hclk) disable iff (!hresetn)
		ce && ack_vec == '0 |=> (status_bits & $past(status_bits)) == $past(status_bits);
	endproperty
	a_disable_keeps: assert property (p_disable_keeps) else $error("status lost without ack");

	property p_fast_hold;
		@(posedge hclk) disable iff (!hresetn)
		fast_state == pic_pkg::FAST_WAIT && !ack_event && master_request_enable
			|=> $stable(vector_address);
	endproperty
	a_fast_hold: assert property (p_fast_hold) else $error("vector changed before ack");

	property p_edge_pulse;
		@(posedge hclk) disable iff (!hresetn)
		ce && !IRQ_IS_LEVEL && irq |=> !irq;
	endproperty
	a_edge_pulse: assert property (p_edge_pulse) else $error("edge irq wider than one cycle");

	c_irq_rise:  cover property (@(posedge hclk) disable iff (!hresetn) $rose(irq));
	c_fast_ack:  cover property (@(posedge hclk) disable iff (!hresetn) ack_event && fast_ack_vec != '0);
	c_sw_test:   cover property (@(posedge hclk) disable iff (!hresetn) sw_set != '0);
	c_hw_locked: cover property (@(posedge hclk) disable iff (!hresetn) $rose(hardware_input_enable));

endmodule : priority_interrupt_controller

`default_nettype wire

// >>> sim/processor_model.sv
// Purpose: Processor core stand-in that takes fast vectors and acknowledges them.
// Assumes: Level request output; one acknowledge per rising edge of processor_ack.
// Notes:   The acknowledge is held 4 cycles, then a long quiet gap follows.
`timescale 1ns/100ps
`default_nettype none
module processor_model #(
	parameter int unsigned DELAY = 3
) (
	// Clock and reset.
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// Request side.
	input  wire logic        answer,
	input  wire logic        irq,
	input  wire logic [31:0] vector_address,
	// Acknowledge side.
	output logic             processor_ack,
	output logic [31:0]      taken_vector,
	output logic [7:0]       n_acks
);
	int unsigned phase;

	// The quiet gap keeps a request that has not yet fallen from being taken twice.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			phase         <= 0;
			processor_ack <= 1'b0;
			taken_vector  <= 32'h0;
			n_acks        <= 8'h0;
		end else if (phase == 0) begin
			if (irq && answer) begin
				phase <= 1;
			end
		end else begin
			phase <= (phase == DELAY + 14) ? 0 : phase + 1;
			if (phase == DELAY) begin
				processor_ack <= 1'b1;
				taken_vector  <= vector_address;
				n_acks        <= n_acks + 8'h1;
			end
			if (phase == DELAY + 4) begin
				processor_ack <= 1'b0;
			end
		end
	end
endmodule : processor_model
`default_nettype wire

// >>> sim/priority_interrupt_controller_test.sv
// Purpose: Self-checking bench of the priority interrupt controller.
// Assumes: Eight inputs, input zero level sensitive, all others rising edge.
// Notes:   Hardware input enable is write-once, so the software mode runs first.
`timescale 1ns/100ps
`default_nettype none
module priority_interrupt_controller_test;
	logic        hclk;
	logic        hresetn;
	logic        ce;
	logic        hsel;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [2:0]  hsize;
	logic [31:0] hwdata;
	logic        hreadyout;
	logic        hresp;
	logic [31:0] hrdata;
	logic [7:0]  intr;
	logic        processor_ack;
	logic        irq;
	logic [31:0] vector_address;
	logic        answer;
	logic [31:0] taken_vector;
	logic [7:0]  n_acks;
	int          n_errors;
	int          checks_done;

	// Clock of 25 ns period.
	always #12.5 hclk = ~hclk;

	priority_interrupt_controller #(.NUM_INTR(8), .KIND_EDGE(8'hFE)) u_priority_interrupt_controller (
		.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.intr(intr), .processor_ack(processor_ack), .irq(irq),
		.vector_address(vector_address));

	processor_model #(.DELAY(3)) u_processor_model (
		.hclk(hclk), .hresetn(hresetn), .answer(answer), .irq(irq),
		.vector_address(vector_address), .processor_ack(processor_ack),
		.taken_vector(taken_vector), .n_acks(n_acks));

	task automatic report_and_stop();
		if (n_errors == 0 && checks_done > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : report_and_stop

	task automatic give_up();
		n_errors++;
		report_and_stop();
	endtask : give_up

	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_errors++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check

	// Waits for an edge with hready high; a stuck bus ends the run.
	task automatic wait_ready();
		int n;
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (hreadyout !== 1'b1 && n < 64);
		if (hreadyout !== 1'b1) begin
			give_up();
		end
	endtask : wait_ready

	// One single word transfer; the idle edge at the end keeps a read from
	// seeing the value from before a write just made.
	task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] wd,
			output logic [31:0] rv);
		hsel   <= 1'b1;
		htrans <= 2'h2;
		haddr  <= {20'h0, a};
		hwrite <= wr;
		wait_ready();
		hsel   <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		wait_ready();
		rv = hrdata;
		@(posedge hclk);
	endtask : bus

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] v;
		bus(1'b1, a, d, v);
	endtask : wr

	task automatic rd(input string nm, input logic [11:0] a, input logic [31:0] exp);
		logic [31:0] v;
		bus(1'b0, a, 32'h0, v);
		check(nm, v, exp);
	endtask : rd

	task automatic wait_irq(input logic lvl);
		int n;
		for (n = 0; n < 100 && irq !== lvl; n++) @(posedge hclk);
		if (irq !== lvl) begin
			give_up();
		end
	endtask : wait_irq

	task automatic pulse(input logic [7:0] bits);
		intr <= intr | bits;
		repeat (5) @(posedge hclk);
		intr <= intr & ~bits;
		@(posedge hclk);
	endtask : pulse

	task automatic after_reset();
		check("hresp", {31'h0, hresp}, 32'h0);
		check("irq idle", {31'h0, irq}, 32'h0);
		check("vector idle", vector_address, 32'h0);
		rd("master", pic_pkg::OFS_MASTER, 32'h0);
		rd("enable", pic_pkg::OFS_ENABLE, 32'h0);
		rd("index idle", pic_pkg::OFS_VECTOR_IDX, 32'hFFFF_FFFF);
		rd("unmapped", 12'h040, 32'h0);
	endtask : after_reset

	task automatic software_mode();
		wr(pic_pkg::OFS_ENABLE, 32'h9);
		wr(pic_pkg::OFS_STATUS, 32'h28);
		rd("status", pic_pkg::OFS_STATUS, 32'h28);
		rd("pending", pic_pkg::OFS_PENDING, 32'h8);
		rd("index", pic_pkg::OFS_VECTOR_IDX, 32'h3);
		check("irq gated", {31'h0, irq}, 32'h0);
		wr(pic_pkg::OFS_MASTER, 32'h1);
		wait_irq(1'b1);
		wr(pic_pkg::OFS_STATUS, 32'h1);
		rd("index", pic_pkg::OFS_VECTOR_IDX, 32'h0);
		wr(pic_pkg::OFS_CLR_ENABLE, 32'h1);
		rd("enable", pic_pkg::OFS_ENABLE, 32'h8);
		rd("status", pic_pkg::OFS_STATUS, 32'h29);
		wr(pic_pkg::OFS_SET_ENABLE, 32'h20);
		rd("enable", pic_pkg::OFS_ENABLE, 32'h28);
		wr(pic_pkg::OFS_MASTER, 32'h0);
		@(posedge hclk); // The request register drops one edge after the write lands.
		check("irq masked", {31'h0, irq}, 32'h0);
		wr(pic_pkg::OFS_ACK, 32'h0);
		rd("status", pic_pkg::OFS_STATUS, 32'h29);
		wr(pic_pkg::OFS_ACK, 32'h29);
		rd("status", pic_pkg::OFS_STATUS, 32'h0);
		// A write while the clock enable is low must leave every register untouched.
		ce <= 1'b0;
		wr(pic_pkg::OFS_STATUS, 32'h2);
		ce <= 1'b1;
		rd("frozen status", pic_pkg::OFS_STATUS, 32'h0);
	endtask : software_mode

	task automatic hardware_mode();
		wr(pic_pkg::OFS_MASTER, 32'h3);
		wr(pic_pkg::OFS_MASTER, 32'h1);
		rd("master", pic_pkg::OFS_MASTER, 32'h3);
		wr(pic_pkg::OFS_STATUS, 32'h2);
		rd("status", pic_pkg::OFS_STATUS, 32'h0);
		wr(pic_pkg::OFS_ENABLE, 32'h5);
		pulse(8'h04);
		wait_irq(1'b1);
		rd("status", pic_pkg::OFS_STATUS, 32'h4);
		wr(pic_pkg::OFS_ACK, 32'h4);
		wait_irq(1'b0);
		intr[0] <= 1'b1;
		wait_irq(1'b1);
		wr(pic_pkg::OFS_ACK, 32'h1);
		rd("status", pic_pkg::OFS_STATUS, 32'h1);
		intr[0] <= 1'b0;
		repeat (6) @(posedge hclk);
		wr(pic_pkg::OFS_ACK, 32'h1);
		rd("status", pic_pkg::OFS_STATUS, 32'h0);
	endtask : hardware_mode

	task automatic fast_mode();
		int n;
		wr(pic_pkg::OFS_MASTER, 32'h2);
		wr(pic_pkg::OFS_VECTOR_BASE + 12'h004, 32'h1230);
		wr(pic_pkg::OFS_VECTOR_BASE + 12'h010, 32'h4560);
		rd("vector reg", pic_pkg::OFS_VECTOR_BASE + 12'h004, 32'h1230);
		wr(pic_pkg::OFS_MODE, 32'h8000_0012);
		rd("mode", pic_pkg::OFS_MODE, 32'h12);
		wr(pic_pkg::OFS_ENABLE, 32'h12);
		wr(pic_pkg::OFS_MASTER, 32'h3);
		pulse(8'h12);
		wait_irq(1'b1);
		@(posedge hclk);
		check("vector out", vector_address, 32'h1230);
		answer <= 1'b1;
		for (n = 0; n < 300 && n_acks !== 8'h02; n++) @(posedge hclk);
		if (n_acks !== 8'h02) begin
			give_up();
		end
		check("taken vector", taken_vector, 32'h4560);
		wait_irq(1'b0);
		rd("status", pic_pkg::OFS_STATUS, 32'h0);
	endtask : fast_mode

	// Inputs settle at time zero; reset is released just after an edge.
	initial begin
		hclk        = 1'b0;
		hresetn     = 1'b0;
		ce          = 1'b1;
		hsel        = 1'b0;
		haddr       = 32'h0;
		htrans      = 2'h0;
		hwrite      = 1'b0;
		hsize       = 3'h2;
		hwdata      = 32'h0;
		intr        = 8'h0;
		answer      = 1'b0;
		n_errors    = 0;
		checks_done = 0;
		repeat (20) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		after_reset();
		software_mode();
		hardware_mode();
		fast_mode();
		report_and_stop();
	end
endmodule : priority_interrupt_controller_test
`default_nettype wire
